/* logic/dmie_pkg.sv */
// Shared constants and types for the data-move instruction executor
package dmie_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W    = 8;
	localparam int PTR_W     = 16;
	localparam int BANK_W    = 6;
	localparam int LATCH_W   = 7;
	localparam int FADDR_W   = 7;
	localparam int OFS_W     = 6;
	localparam int MODE_W    = 2;

	// ----------------------------------------
	// Pointer update modes
	// ----------------------------------------
	localparam logic [MODE_W-1:0] MODE_PRE_INC  = 2'h0;
	localparam logic [MODE_W-1:0] MODE_PRE_DEC  = 2'h1;
	localparam logic [MODE_W-1:0] MODE_POST_INC = 2'h2;
	localparam logic [MODE_W-1:0] MODE_POST_DEC = 2'h3;

	// ----------------------------------------
	// Indirect access register locations in each bank
	// ----------------------------------------
	localparam logic [FADDR_W-1:0] IND0_ADDR = 7'h00;
	localparam logic [FADDR_W-1:0] IND1_ADDR = 7'h01;

	// ----------------------------------------
	// Reset values, plus a pointer constant of one (PTR_ONE)
	// ----------------------------------------
	localparam logic [PTR_W-1:0]   PTR_RST   = 16'h0000;
	localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
	localparam logic [BANK_W-1:0]  BANK_RST  = 6'h00;
	localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
	localparam logic [PTR_W-1:0]   PTR_ONE   = 16'h0001;

	// ----------------------------------------
	// Decoded operations
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE,
		OP_INDIRECT_LOAD,
		OP_BANK_LITERAL,
		OP_PROG_LATCH_LITERAL,
		OP_ACC_LITERAL,
		OP_ACC_STORE
	} dmie_op_e;

endpackage

/* logic/dmie_ptr_unit.sv */
// Effective address and next value of one file-select pointer
`timescale 1ns/1ns
module dmie_ptr_unit #(
	parameter int PTR_WIDTH = 16
) (
	input  wire logic [PTR_WIDTH-1:0]           ptr,
	input  wire logic [dmie_pkg::MODE_W-1:0]    mode,
	input  wire logic                           relative,
	input  wire logic [dmie_pkg::OFS_W-1:0]     offset,
	output wire logic [PTR_WIDTH-1:0]           eff_addr,
	output wire logic [PTR_WIDTH-1:0]           next_ptr
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Sign extension of the offset needs a pointer wider than the offset
	if (PTR_WIDTH <= dmie_pkg::OFS_W)
	begin : g_bad_width
		$error("PTR_WIDTH must exceed the offset width");
	end

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	// Plain truncating adds give wrap-around with no fault
	wire logic [PTR_WIDTH-1:0] ptr_inc = PTR_WIDTH'(ptr + PTR_WIDTH'(1));
	wire logic [PTR_WIDTH-1:0] ptr_dec = PTR_WIDTH'(ptr - PTR_WIDTH'(1));
	wire logic [PTR_WIDTH-1:0] ofs_ext = {{(PTR_WIDTH-dmie_pkg::OFS_W){offset[dmie_pkg::OFS_W-1]}}, offset};
	wire logic [PTR_WIDTH-1:0] ptr_rel = PTR_WIDTH'(ptr + ofs_ext);

	wire logic is_inc = (mode == dmie_pkg::MODE_PRE_INC) || (mode == dmie_pkg::MODE_POST_INC);
	wire logic is_pre = (mode == dmie_pkg::MODE_PRE_INC) || (mode == dmie_pkg::MODE_PRE_DEC);
	wire logic [PTR_WIDTH-1:0] stepped = is_inc ? ptr_inc : ptr_dec;

	// ----------------------------------------
	// Selection
	// ----------------------------------------
	assign eff_addr = relative ? ptr_rel : (is_pre ? stepped : ptr);
	assign next_ptr = relative ? ptr : stepped;

endmodule

/* logic/dmie_core.sv */
// Data-move instruction executor: indirect load, literal moves, accumulator store
`timescale 1ns/1ns
module dmie_core #(
	parameter int PTR_WIDTH = 16
) (
	input  wire logic                               core_clk,
	input  wire logic                               reset_n,
	input  wire logic                               instr_valid,
	input  wire dmie_pkg::dmie_op_e                 instr_op,
	input  wire logic                               ptr_sel,
	input  wire logic [dmie_pkg::MODE_W-1:0]        pointer_mode_field,
	input  wire logic                               ptr_relative,
	input  wire logic [dmie_pkg::OFS_W-1:0]         ptr_offset,
	input  wire logic [dmie_pkg::DATA_W-1:0]        literal,
	input  wire logic [dmie_pkg::FADDR_W-1:0]       file_addr,
	input  wire logic                               ptr_load_en,
	input  wire logic                               ptr_load_sel,
	input  wire logic [PTR_WIDTH-1:0]               ptr_load_value,
	output wire logic                               mem_rd_en,
	output wire logic [PTR_WIDTH-1:0]               mem_rd_addr,
	input  wire logic [dmie_pkg::DATA_W-1:0]        mem_rd_data,
	output wire logic                               mem_wr_en,
	output wire logic [PTR_WIDTH-1:0]               mem_wr_addr,
	output wire logic [dmie_pkg::DATA_W-1:0]        mem_wr_data,
	output wire logic [dmie_pkg::DATA_W-1:0]        acc,
	output wire logic                               zero_flag,
	output wire logic [dmie_pkg::BANK_W-1:0]        bank_selection_register,
	output wire logic [dmie_pkg::LATCH_W-1:0]       pc_high_latch,
	output wire logic [PTR_WIDTH-1:0]               file_select_pointer0,
	output wire logic [PTR_WIDTH-1:0]               file_select_pointer1
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Direct addresses are bank plus file offset, so the pointer must cover them
	if (PTR_WIDTH < dmie_pkg::BANK_W + dmie_pkg::FADDR_W)
	begin : g_bad_width
		$error("PTR_WIDTH too small for banked direct addresses");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [PTR_WIDTH-1:0]              fsr0_q;
	logic [PTR_WIDTH-1:0]              fsr1_q;
	logic [PTR_WIDTH-1:0]              fsr0_d;
	logic [PTR_WIDTH-1:0]              fsr1_d;
	logic [dmie_pkg::DATA_W-1:0]       acc_q;
	logic [dmie_pkg::DATA_W-1:0]       acc_d;
	logic                              z_q;
	logic                              z_d;
	logic [dmie_pkg::BANK_W-1:0]       bsr_q;
	logic [dmie_pkg::BANK_W-1:0]       bsr_d;
	logic [dmie_pkg::LATCH_W-1:0]      pc_high_latch_q;
	logic [dmie_pkg::LATCH_W-1:0]      pc_high_latch_d;
	logic                              wr_en_q;
	logic [PTR_WIDTH-1:0]              wr_addr_q;
	logic [dmie_pkg::DATA_W-1:0]       wr_data_q;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire logic do_iload  = instr_valid && (instr_op == dmie_pkg::OP_INDIRECT_LOAD);
	wire logic do_bank   = instr_valid && (instr_op == dmie_pkg::OP_BANK_LITERAL);
	wire logic do_latch  = instr_valid && (instr_op == dmie_pkg::OP_PROG_LATCH_LITERAL);
	wire logic do_acclit = instr_valid && (instr_op == dmie_pkg::OP_ACC_LITERAL);
	wire logic do_store  = instr_valid && (instr_op == dmie_pkg::OP_ACC_STORE);

	// ----------------------------------------
	// Pointer arithmetic
	// ----------------------------------------
	// One shared unit: only one pointer moves per instruction
	wire logic [PTR_WIDTH-1:0] sel_ptr = ptr_sel ? fsr1_q : fsr0_q;
	wire logic [PTR_WIDTH-1:0] eff_addr;
	wire logic [PTR_WIDTH-1:0] next_ptr;

	dmie_ptr_unit #(
		.PTR_WIDTH (PTR_WIDTH)
	) u_ptr_unit (
		.ptr      (sel_ptr),
		.mode     (pointer_mode_field),
		.relative (ptr_relative),
		.offset   (ptr_offset),
		.eff_addr (eff_addr),
		.next_ptr (next_ptr)
	);

	// ----------------------------------------
	// Memory read for indirect load
	// ----------------------------------------
	// Read data must return in the same cycle for a single-cycle load
	assign mem_rd_en   = do_iload;
	assign mem_rd_addr = eff_addr;

	// ----------------------------------------
	// Store address, with indirect redirection
	// ----------------------------------------
	wire logic st_ind0 = (file_addr == dmie_pkg::IND0_ADDR);
	wire logic st_ind1 = (file_addr == dmie_pkg::IND1_ADDR);
	wire logic [PTR_WIDTH-1:0] direct_addr = PTR_WIDTH'({bsr_q, file_addr});
	wire logic [PTR_WIDTH-1:0] store_addr = st_ind0 ? fsr0_q :
	                                        st_ind1 ? fsr1_q : direct_addr;

	// ----------------------------------------
	// Next-state selection
	// ----------------------------------------
	wire logic ld0 = ptr_load_en && !ptr_load_sel;
	wire logic ld1 = ptr_load_en && ptr_load_sel;
	wire logic upd0 = do_iload && !ptr_sel;
	wire logic upd1 = do_iload && ptr_sel;

	// Instruction update wins over a side load in the same cycle
	assign fsr0_d = upd0 ? next_ptr : (ld0 ? ptr_load_value : fsr0_q);
	assign fsr1_d = upd1 ? next_ptr : (ld1 ? ptr_load_value : fsr1_q);

	assign acc_d = do_iload  ? mem_rd_data :
	               do_acclit ? literal : acc_q;

	// Only the indirect load touches zero
	assign z_d = do_iload ? (mem_rd_data == '0) : z_q;

	assign bsr_d    = do_bank ? literal[dmie_pkg::BANK_W-1:0] : bsr_q;
	assign pc_high_latch_d = do_latch ? literal[dmie_pkg::LATCH_W-1:0] : pc_high_latch_q;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fsr0_q <= PTR_WIDTH'(dmie_pkg::PTR_RST);
			fsr1_q <= PTR_WIDTH'(dmie_pkg::PTR_RST);
		end
		else
		begin
			fsr0_q <= fsr0_d;
			fsr1_q <= fsr1_d;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			acc_q    <= dmie_pkg::ACC_RST;
			z_q      <= 1'b0;
			bsr_q    <= dmie_pkg::BANK_RST;
			pc_high_latch_q <= dmie_pkg::LATCH_RST;
		end
		else
		begin
			acc_q    <= acc_d;
			z_q      <= z_d;
			bsr_q    <= bsr_d;
			pc_high_latch_q <= pc_high_latch_d;
		end
	end

	// Store is issued from flops; the write lands one edge after the instruction
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_en_q   <= 1'b0;
			wr_addr_q <= PTR_WIDTH'(dmie_pkg::PTR_RST);
			wr_data_q <= dmie_pkg::ACC_RST;
		end
		else
		begin
			wr_en_q <= do_store;
			if (do_store)
			begin
				wr_addr_q <= store_addr;
				wr_data_q <= acc_q;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign mem_wr_en               = wr_en_q;
	assign mem_wr_addr             = wr_addr_q;
	assign mem_wr_data             = wr_data_q;
	assign acc                     = acc_q;
	assign zero_flag               = z_q;
	assign bank_selection_register = bsr_q;
	assign pc_high_latch           = pc_high_latch_q;
	assign file_select_pointer0    = fsr0_q;
	assign file_select_pointer1    = fsr1_q;

endmodule

/* tb/dmie_core_checker.sv */
// Port-level assertions for the data-move instruction executor
`timescale 1ns/1ns
module dmie_chk #(
	parameter int PTR_WIDTH = 16
) (
	input wire logic                         core_clk,
	input wire logic                         reset_n,
	input wire logic                         instr_valid,
	input wire dmie_pkg::dmie_op_e           instr_op,
	input wire logic                         ptr_sel,
	input wire logic [dmie_pkg::MODE_W-1:0]  pointer_mode_field,
	input wire logic                         ptr_relative,
	input wire logic [dmie_pkg::OFS_W-1:0]   ptr_offset,
	input wire logic [dmie_pkg::DATA_W-1:0]  literal,
	input wire logic [PTR_WIDTH-1:0]         mem_rd_addr,
	input wire logic [dmie_pkg::DATA_W-1:0]  mem_rd_data,
	input wire logic                         mem_wr_en,
	input wire logic [dmie_pkg::DATA_W-1:0]  mem_wr_data,
	input wire logic [dmie_pkg::DATA_W-1:0]  acc,
	input wire logic                         zero_flag,
	input wire logic [dmie_pkg::BANK_W-1:0]  bank_selection_register,
	input wire logic [dmie_pkg::LATCH_W-1:0] pc_high_latch,
	input wire logic [PTR_WIDTH-1:0]         file_select_pointer0,
	input wire logic [PTR_WIDTH-1:0]         file_select_pointer1
);
	// ----------------------------------------
	// Decodes
	// ----------------------------------------
	// Sized one keeps pointer sums at pointer width, so wrap is checked
	localparam logic [PTR_WIDTH-1:0] ONE = 1;
	wire logic ld = instr_valid && (instr_op == dmie_pkg::OP_INDIRECT_LOAD);
	wire logic st = instr_valid && (instr_op == dmie_pkg::OP_ACC_STORE);
	wire logic step0 = ld && !ptr_relative && !ptr_sel;
	wire logic [PTR_WIDTH-1:0] ofs_x = {{(PTR_WIDTH-6){ptr_offset[5]}}, ptr_offset};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_load_to_acc: assert property (
		ld |=> acc == $past(mem_rd_data) && zero_flag == ($past(mem_rd_data) == 8'h00))
		else $error("indirect load result wrong");
	a_pre_addr: assert property (
		step0 && !pointer_mode_field[1] |-> mem_rd_addr == (pointer_mode_field[0] ?
		file_select_pointer0 - ONE : file_select_pointer0 + ONE)) else $error("pre-step address wrong");
	a_ptr_step: assert property (
		step0 |=> file_select_pointer0 == ($past(pointer_mode_field[0]) ? $past(file_select_pointer0) - ONE
		: $past(file_select_pointer0) + ONE)) else $error("pointer step wrong");
	a_rel_addr: assert property (
		ld && ptr_relative && ptr_sel |-> mem_rd_addr == file_select_pointer1 + ofs_x)
		else $error("relative address wrong");
	a_rel_hold: assert property (
		ld && ptr_relative && ptr_sel |=> $stable(file_select_pointer1)) else $error("relative form moved pointer");
	a_bank_lit: assert property (
		instr_valid && instr_op == dmie_pkg::OP_BANK_LITERAL |=> bank_selection_register == $past(literal[5:0])
		&& $stable(zero_flag)) else $error("bank literal wrong");
	a_acc_lit: assert property (
		instr_valid && instr_op == dmie_pkg::OP_ACC_LITERAL |=> acc == $past(literal) && $stable(zero_flag))
		else $error("accumulator literal wrong");
	a_latch_lit: assert property (
		instr_valid && instr_op == dmie_pkg::OP_PROG_LATCH_LITERAL
		|=> pc_high_latch == $past(literal[6:0]) && $stable(zero_flag))
		else $error("latch literal wrong");
	a_store_out: assert property (
		st |=> mem_wr_en && mem_wr_data == $past(acc) && $stable(zero_flag)) else $error("store output wrong");
	c_rel: cover property (ld && ptr_relative);
	c_post_dec: cover property (step0 && pointer_mode_field == dmie_pkg::MODE_POST_DEC);
	c_store_pair: cover property (st ##1 st);
endmodule

/* tb/dmie_core_test.sv */
// Self-checking bench for the data-move instruction executor
`timescale 1ns/1ns
module dmie_core_test;
	logic core_clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, ptr_sel = 1'b0, ptr_relative = 1'b0;
	logic ptr_load_en = 1'b0, ptr_load_sel = 1'b0, mem_rd_en, mem_wr_en, zero_flag;
	dmie_pkg::dmie_op_e instr_op = dmie_pkg::OP_NONE;
	logic [1:0] pointer_mode_field = '0;
	logic [5:0] ptr_offset = '0, bank_selection_register;
	logic [6:0] file_addr = '0, pc_high_latch;
	logic [7:0] literal = '0, mem_wr_data, acc;
	logic [15:0] ptr_load_value = '0, mem_rd_addr, mem_wr_addr, file_select_pointer0, file_select_pointer1;
	int err_total = 0, tests_run = 0;
	// Fixed contents so every read value follows from its address
	wire logic [7:0] mem_rd_data = mem_rd_addr[7:0] ^ 8'hA5;
	dmie_core i_dut (
		.core_clk                (core_clk),
		.reset_n                 (reset_n),
		.instr_valid             (instr_valid),
		.instr_op                (instr_op),
		.ptr_sel                 (ptr_sel),
		.pointer_mode_field      (pointer_mode_field),
		.ptr_relative            (ptr_relative),
		.ptr_offset              (ptr_offset),
		.literal                 (literal),
		.file_addr               (file_addr),
		.ptr_load_en             (ptr_load_en),
		.ptr_load_sel            (ptr_load_sel),
		.ptr_load_value          (ptr_load_value),
		.mem_rd_en               (mem_rd_en),
		.mem_rd_addr             (mem_rd_addr),
		.mem_rd_data             (mem_rd_data),
		.mem_wr_en               (mem_wr_en),
		.mem_wr_addr             (mem_wr_addr),
		.mem_wr_data             (mem_wr_data),
		.acc                     (acc),
		.zero_flag               (zero_flag),
		.bank_selection_register (bank_selection_register),
		.pc_high_latch           (pc_high_latch),
		.file_select_pointer0    (file_select_pointer0),
		.file_select_pointer1    (file_select_pointer1)
	);
	initial forever #5 core_clk = ~core_clk;
	function automatic logic [7:0] mem_of(input logic [15:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step;
		@(posedge core_clk);
		#1;
	endtask
	task automatic put(input dmie_pkg::dmie_op_e op, input logic [7:0] lit, input logic sel, input logic [1:0] md,
			input logic rel, input logic [5:0] ofs);
		instr_valid = 1'b1;
		ptr_load_en = 1'b0;
		instr_op = op;
		literal = lit;
		file_addr = lit[6:0];
		ptr_sel = sel;
		pointer_mode_field = md;
		ptr_relative = rel;
		ptr_offset = ofs;
		// Read strobe is combinational, so look before the edge
		#1;
		chk(16'(mem_rd_en), 16'(op == dmie_pkg::OP_INDIRECT_LOAD));
		step;
	endtask
	task automatic ld(input logic sel, input logic [15:0] val);
		instr_valid = 1'b0;
		ptr_load_en = 1'b1;
		ptr_load_sel = sel;
		ptr_load_value = val;
		step;
	endtask
	task automatic t_lits;
		chk({acc, zero_flag, pc_high_latch} | file_select_pointer0 | file_select_pointer1, 16'h0000);
		put(dmie_pkg::OP_BANK_LITERAL, 8'hFF, 1'b0, 2'h0, 1'b0, 6'h00);
		chk(16'(bank_selection_register), 16'h003F);
		put(dmie_pkg::OP_PROG_LATCH_LITERAL, 8'hFF, 1'b0, 2'h0, 1'b0, 6'h00);
		chk(16'(pc_high_latch), 16'h007F);
		put(dmie_pkg::OP_ACC_LITERAL, 8'h00, 1'b0, 2'h0, 1'b0, 6'h00);
		chk({acc, 7'h00, zero_flag}, 16'h0000);
		$display("t_lits done");
	endtask
	task automatic t_modes;
		logic [15:0] base, nxt, ea;
		for (int m = 0; m < 4; m++)
		begin
			base = m[0] ? 16'h0000 : 16'hFFFF;
			nxt = m[0] ? base - 16'h0001 : base + 16'h0001;
			ea = m[1] ? base : nxt;
			ld(1'b0, base);
			put(dmie_pkg::OP_INDIRECT_LOAD, 8'h00, 1'b0, 2'(m), 1'b0, 6'h00);
			chk({acc, 7'h00, zero_flag}, {mem_of(ea), 8'h00});
			chk(file_select_pointer0, nxt);
		end
		$display("t_modes done");
	endtask
	task automatic t_rel;
		ld(1'b1, 16'h00C5);
		ld(1'b0, 16'h1234);
		put(dmie_pkg::OP_INDIRECT_LOAD, 8'h00, 1'b1, 2'h3, 1'b1, 6'h20);
		chk({acc, 7'h00, zero_flag}, 16'h0001);
		put(dmie_pkg::OP_INDIRECT_LOAD, 8'h00, 1'b1, 2'h0, 1'b1, 6'h1F);
		chk({acc, 7'h00, zero_flag}, {mem_of(16'h00E4), 8'h00});
		chk(file_select_pointer1, 16'h00C5);
		chk(file_select_pointer0, 16'h1234);
		put(dmie_pkg::OP_INDIRECT_LOAD, 8'h00, 1'b1, 2'h2, 1'b0, 6'h00);
		chk({acc, 7'h00, zero_flag}, {mem_of(16'h00C5), 8'h00});
		chk(file_select_pointer1, 16'h00C6);
		chk(file_select_pointer0, 16'h1234);
		$display("t_rel done");
	endtask
	task automatic t_store;
		put(dmie_pkg::OP_ACC_LITERAL, 8'h3C, 1'b0, 2'h0, 1'b0, 6'h00);
		put(dmie_pkg::OP_ACC_STORE, 8'h7F, 1'b0, 2'h0, 1'b0, 6'h00);
		chk(16'({mem_wr_en, mem_wr_data}), 16'h013C);
		chk(mem_wr_addr, 16'h1FFF);
		put(dmie_pkg::OP_ACC_STORE, 8'h00, 1'b0, 2'h0, 1'b0, 6'h00);
		chk(16'({mem_wr_en, 7'h00, zero_flag}), 16'h0100);
		chk(mem_wr_addr, 16'h1234);
		put(dmie_pkg::OP_ACC_STORE, 8'h01, 1'b0, 2'h0, 1'b0, 6'h00);
		chk(16'({mem_wr_en, mem_wr_data}), 16'h013C);
		chk(mem_wr_addr, 16'h00C6);
		instr_valid = 1'b0;
		step;
		chk(16'(mem_wr_en), 16'h0000);
		$display("t_store done");
	endtask
	task automatic summarize;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
		t_lits;
		t_modes;
		t_rel;
		t_store;
		summarize;
	end
	// Whole run is well under a hundred cycles
	initial
	begin
		#20000;
		err_total++;
		summarize;
	end
endmodule
bind dmie_core dmie_chk #(
	.PTR_WIDTH (PTR_WIDTH)
) u_chk (
	.core_clk                (core_clk),
	.reset_n                 (reset_n),
	.instr_valid             (instr_valid),
	.instr_op                (instr_op),
	.ptr_sel                 (ptr_sel),
	.pointer_mode_field      (pointer_mode_field),
	.ptr_relative            (ptr_relative),
	.ptr_offset              (ptr_offset),
	.literal                 (literal),
	.mem_rd_addr             (mem_rd_addr),
	.mem_rd_data             (mem_rd_data),
	.mem_wr_en               (mem_wr_en),
	.mem_wr_data             (mem_wr_data),
	.acc                     (acc),
	.zero_flag               (zero_flag),
	.bank_selection_register (bank_selection_register),
	.pc_high_latch           (pc_high_latch),
	.file_select_pointer0    (file_select_pointer0),
	.file_select_pointer1    (file_select_pointer1)
);
